// ==== rtl/mdio_frame_engine.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "phy_page_cfg.svh"
module mdio_frame_engine
    import phy_page_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    // Management pins
    input  wire logic mdc_i,
    input  wire logic mdio_i,
    output logic      mdio_o,
    output logic      mdio_oe_n_o,
    // Register access
    mgmt_if.engine    mif
);

    // Synchronisers start at the idle-high pin level, so no false MDC edge follows reset
    localparam mdio_eng_t ENG_RESET = '{state: ST_PREAMBLE, oe_n: 1'b1, mdc_s1: 1'b1, mdc_s2: 1'b1, mdc_d: 1'b1,
                                        mdio_s1: 1'b1, mdio_s2: 1'b1, default: '0};

    mdio_eng_t  r;
    mdio_eng_t  n;
    logic       mdc_rise;
    logic       mdc_fall;
    logic [1:0] opcode;

    assign mdc_rise = r.mdc_s2 & ~r.mdc_d;
    assign mdc_fall = ~r.mdc_s2 & r.mdc_d;

    always_comb begin
        n = r;
        opcode = {r.shreg[0], r.mdio_s2};
        n.rd_stb = 1'b0;
        n.wr_stb = 1'b0;
        n.mdc_s1 = mdc_i;
        n.mdc_s2 = r.mdc_s1;
        n.mdc_d = r.mdc_s2;
        n.mdio_s1 = mdio_i;
        n.mdio_s2 = r.mdio_s1;
        if (mdc_rise) begin
            case (r.state)
                ST_PREAMBLE: begin
                    if (r.mdio_s2) begin
                        if (r.cnt != `PREAMBLE_LEN) n.cnt = r.cnt + 6'h01;
                    end else begin
                        if (r.cnt == `PREAMBLE_LEN) n.state = ST_START;
                        n.cnt = '0;
                    end
                end
                ST_START: n.state = r.mdio_s2 ? ST_OP : ST_PREAMBLE;
                ST_OP: begin
                    n.shreg = {r.shreg[14:0], r.mdio_s2};
                    n.cnt = r.cnt + 6'h01;
                    if (r.cnt == `OP_LAST) begin
                        n.is_read = (opcode == `OP_READ);
                        n.state = (opcode == `OP_READ || opcode == `OP_WRITE) ? ST_ADDR : ST_PREAMBLE;
                        n.cnt = '0;
                    end
                end
                ST_ADDR: begin
                    n.shreg = {r.shreg[14:0], r.mdio_s2};
                    n.cnt = r.cnt + 6'h01;
                    if (r.cnt == `ADDR_LAST) begin
                        n.phy_hit = (n.shreg[9:5] == PHY_ADDR);
                        n.reg_addr = n.shreg[4:0];
                        n.rd_stb = r.is_read & n.phy_hit;
                        n.state = ST_TA;
                        n.cnt = '0;
                    end
                end
                ST_TA: begin
                    n.cnt = r.cnt + 6'h01;
                    if (r.cnt == `TA_LAST) begin
                        n.state = ST_DATA;
                        n.cnt = '0;
                    end
                end
                ST_DATA: begin
                    if (!r.is_read) n.shreg = {r.shreg[14:0], r.mdio_s2};
                    n.cnt = r.cnt + 6'h01;
                    if (r.cnt == `DATA_LAST) begin
                        n.state = ST_PREAMBLE;
                        n.cnt = '0;
                        n.oe_n = 1'b1;
                        n.wr_stb = ~r.is_read & r.phy_hit;
                    end
                end
                default: begin
                    n.state = ST_PREAMBLE;
                    n.cnt = '0;
                end
            endcase
        end else if (mdc_fall && r.is_read && r.phy_hit) begin
            // Second turnaround bit is driven low, then data MSB first
            if (r.state == ST_TA && r.cnt == `TA_LAST) begin
                n.oe_n = 1'b0;
                n.mdio_out = 1'b0;
                n.shreg = mif.rdata;
            end else if (r.state == ST_DATA) begin
                n.mdio_out = r.shreg[15];
                n.shreg = {r.shreg[14:0], 1'b0};
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            r <= ENG_RESET;
        end else begin
            r <= n;
        end
    end

    assign mdio_o = r.mdio_out;
    assign mdio_oe_n_o = r.oe_n;
    assign mif.rd_stb = r.rd_stb;
    assign mif.wr_stb = r.wr_stb;
    assign mif.addr = r.reg_addr;
    assign mif.wdata = r.shreg;

endmodule
`default_nettype wire

// ==== rtl/phy_page_counters_pcs_config.sv ====
// Summary of operation
// - Two-bit page index picks the register page seen at addresses 14h-16h.
// - Page 0 extended, 1 test mode, 2 link diagnostics; only page 0 is implemented.
// - Reserved read-only bits ignore writes and read as zero.
// - Eight-bit false carrier tally counts each false carrier event.
// - False carrier tally sticks at FFh.
// - Receive error tally counts carriers holding at least one invalid symbol.
// - Receive error tally rises at most once per carrier event.
// - Carrier events with a collision do not count as receive errors.
// - Receive error tally sticks at its all-ones maximum.
// - Bit 11 set: receive clock free-runs; clear: phase follows alignment.
// - Bit 10 set: true quiet transmit; clear: normal transmit.
// - Bit 9 set forces signal detect reported; clear restores normal.
// - Bit 8 set (reset): link holds on valid signal despite lock loss.
// - Bit 8 clear: link needs valid signal and descrambler lock.
// - Descrambler timeout is 722 us, or 2 ms with bit 7 set.
`timescale 1ns/1ps
`default_nettype none
`include "phy_page_cfg.svh"
module phy_page_counters_pcs_config
    import phy_page_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR       = 5'h01,
    parameter int         DESC_SHORT_CYC = `DESC_SHORT_CYC,
    parameter int         DESC_LONG_CYC  = `DESC_LONG_CYC
) (
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    // Serial management pins
    input  wire logic       mdc_i,
    input  wire logic       mdio_i,
    output logic            mdio_o,
    output logic            mdio_oe_n_o,
    // Receive events
    input  wire logic       false_carrier_i,
    input  wire logic       carrier_valid_i,
    input  wire logic       invalid_symbol_i,
    input  wire logic       collision_i,
    // Signal detect and descrambler
    input  wire logic       signal_level_i,
    input  wire logic       descrambler_lock_i,
    input  wire logic       descrambler_sync_i,
    // Controls and status
    output logic [1:0]      page_select_o,
    output logic            rx_clk_free_run_o,
    output logic            true_quiet_o,
    output logic            signal_detect_o,
    output logic            link_up_o,
    output logic            descrambler_timeout_o
);

    localparam bank_state_t BANK_RESET = '{link_hold: `CTL_HOLD_RST, default: '0};

    mgmt_if mif ();

    bank_state_t r;
    bank_state_t n;
    logic        fc_clr;
    logic        rx_clr;
    logic        rx_count;
    logic [14:0] desc_limit;

    mdio_frame_engine #(
        .PHY_ADDR (PHY_ADDR)
    ) u_engine (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .mdc_i       (mdc_i),
        .mdio_i      (mdio_i),
        .mdio_o      (mdio_o),
        .mdio_oe_n_o (mdio_oe_n_o),
        .mif         (mif.engine)
    );

    // Paged register visible only on the extended page
    function automatic logic page_hit(
        input logic [4:0] addr,
        input logic [1:0] page,
        input logic [4:0] target
    );
        return (page == `PAGE_EXTENDED) && (addr == target);
    endfunction

    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        return (v == `TALLY_MAX) ? v : v + 8'h01;
    endfunction

    function automatic logic [15:0] read_word(
        input logic [4:0]  addr,
        input bank_state_t st
    );
        logic [15:0] w;
        w = 16'h0000;
        if (addr == `ADDR_PAGE_SEL) begin
            w[`PAGE_MSB:`PAGE_LSB] = st.page;
        end else if (page_hit(addr, st.page, `ADDR_FC_TALLY)) begin
            w[`TALLY_MSB:`TALLY_LSB] = st.fc_tally;
        end else if (page_hit(addr, st.page, `ADDR_RX_TALLY)) begin
            w[`TALLY_MSB:`TALLY_LSB] = st.rx_tally;
        end else if (page_hit(addr, st.page, `ADDR_CODING_CTL)) begin
            w[`CTL_FREE_BIT] = st.free_clk;
            w[`CTL_TQ_BIT] = st.true_quiet;
            w[`CTL_SD_BIT] = st.sd_override;
            w[`CTL_HOLD_BIT] = st.link_hold;
            w[`CTL_DESC_BIT] = st.desc_long;
        end
        return w;
    endfunction

    always_comb begin
        n = r;
        fc_clr = mif.rd_stb && page_hit(mif.addr, r.page, `ADDR_FC_TALLY);
        rx_clr = mif.rd_stb && page_hit(mif.addr, r.page, `ADDR_RX_TALLY);
        rx_count = r.in_carrier && !carrier_valid_i && r.err_seen && !r.coll_seen;
        desc_limit = r.desc_long ? 15'(DESC_LONG_CYC - 1) : 15'(DESC_SHORT_CYC - 1);
        n.desc_timeout = 1'b0;

        // Page selector; other pages are not implemented and read as zero
        if (mif.wr_stb && mif.addr == `ADDR_PAGE_SEL) begin
            n.page = mif.wdata[`PAGE_MSB:`PAGE_LSB];
        end

        // Only the defined control bits store; bit 6 and the rest drop
        if (mif.wr_stb && page_hit(mif.addr, r.page, `ADDR_CODING_CTL)) begin
            n.free_clk = mif.wdata[`CTL_FREE_BIT];
            n.true_quiet = mif.wdata[`CTL_TQ_BIT];
            n.sd_override = mif.wdata[`CTL_SD_BIT];
            n.link_hold = mif.wdata[`CTL_HOLD_BIT];
            n.desc_long = mif.wdata[`CTL_DESC_BIT];
        end

        // Read data is caught at the strobe, before any clear lands
        if (mif.rd_stb) begin
            n.rdata = read_word(mif.addr, r);
        end

        // Clear first so an event in the read cycle survives
        n.fc_tally = fc_clr ? 8'h00 : r.fc_tally;
        if (false_carrier_i) begin
            n.fc_tally = sat_inc(n.fc_tally);
        end

        // Errors and collisions are gathered over one carrier event
        n.in_carrier = carrier_valid_i;
        if (carrier_valid_i && !r.in_carrier) begin
            n.err_seen = invalid_symbol_i;
            n.coll_seen = collision_i;
        end else if (carrier_valid_i) begin
            n.err_seen = r.err_seen | invalid_symbol_i;
            n.coll_seen = r.coll_seen | collision_i;
        end

        // Counted once, at the end of the carrier event
        n.rx_tally = rx_clr ? 8'h00 : r.rx_tally;
        if (rx_count) begin
            n.rx_tally = sat_inc(n.rx_tally);
        end

        n.sd = signal_level_i | r.sd_override;

        if (!r.link) begin
            n.link = r.sd && descrambler_lock_i;
        end else if (!r.sd) begin
            n.link = 1'b0;
        end else if (!r.link_hold && !descrambler_lock_i) begin
            n.link = 1'b0;
        end

        // Timer restarts on every sync refresh while locked
        if (!descrambler_lock_i || descrambler_sync_i) begin
            n.desc_cnt = '0;
        end else if (r.desc_cnt == desc_limit) begin
            n.desc_cnt = '0;
            n.desc_timeout = 1'b1;
        end else begin
            n.desc_cnt = r.desc_cnt + 15'h0001;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            r <= BANK_RESET;
        end else begin
            r <= n;
        end
    end

    assign mif.rdata = r.rdata;
    assign page_select_o = r.page;
    assign rx_clk_free_run_o = r.free_clk;
    assign true_quiet_o = r.true_quiet;
    assign signal_detect_o = r.sd;
    assign link_up_o = r.link;
    assign descrambler_timeout_o = r.desc_timeout;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    logic [14:0] desc_limit_q;
    logic        desc_long_q;

    always_ff @(posedge sys_clk_i) begin
        desc_limit_q <= desc_limit;
        desc_long_q <= r.desc_long;
    end

    a_page_write: assert property (
        mif.wr_stb && mif.addr == `ADDR_PAGE_SEL
        |=> r.page == $past(mif.wdata[`PAGE_MSB:`PAGE_LSB])
    ) else $error("page index not taken from write");

    a_page_hidden: assert property (
        mif.rd_stb && r.page != `PAGE_EXTENDED && mif.addr == `ADDR_FC_TALLY
        |=> r.rdata == 16'h0000
    ) else $error("extended register seen on another page");

    a_reserved_zero: assert property (
        mif.rd_stb |=> r.rdata[15:12] == 4'h0 && (mif.addr != `ADDR_FC_TALLY || r.rdata[15:8] == 8'h00)
    ) else $error("reserved bits read nonzero");

    a_page_rsvd: assert property (
        mif.rd_stb && mif.addr == `ADDR_PAGE_SEL |=> r.rdata[15:2] == 14'h0000
    ) else $error("page selector reserved bits read nonzero");

    a_fc_count: assert property (
        false_carrier_i && !fc_clr && r.fc_tally != `TALLY_MAX
        |=> r.fc_tally == $past(r.fc_tally) + 8'h01
    ) else $error("false carrier tally did not step");

    a_fc_stick: assert property (
        r.fc_tally == `TALLY_MAX && !fc_clr |=> r.fc_tally == `TALLY_MAX
    ) else $error("false carrier tally wrapped");

    a_fc_clear: assert property (
        fc_clr ##0 !false_carrier_i |=> r.fc_tally == 8'h00 ##0 r.rdata[7:0] == $past(r.fc_tally)
    ) else $error("read did not return then clear tally");

    a_rx_clear: assert property (
        rx_clr && !rx_count |=> r.rx_tally == 8'h00
    ) else $error("receive error tally not cleared by read");

    a_rx_once: assert property (
        carrier_valid_i && r.in_carrier && !rx_clr |=> r.rx_tally == $past(r.rx_tally)
    ) else $error("receive error tally moved inside carrier");

    a_rx_count: assert property (
        rx_count && !rx_clr && r.rx_tally != `TALLY_MAX
        |=> r.rx_tally == $past(r.rx_tally) + 8'h01
    ) else $error("errored carrier not counted");

    a_rx_collision: assert property (
        r.in_carrier && !carrier_valid_i && r.coll_seen && !rx_clr
        |=> r.rx_tally == $past(r.rx_tally)
    ) else $error("collided carrier was counted");

    a_rx_stick: assert property (
        r.rx_tally == `TALLY_MAX && !rx_clr |=> r.rx_tally == `TALLY_MAX
    ) else $error("receive error tally wrapped");

    a_ctl_free_clk: assert property (
        mif.wr_stb && page_hit(mif.addr, r.page, `ADDR_CODING_CTL)
        |=> rx_clk_free_run_o == $past(mif.wdata[`CTL_FREE_BIT])
            && true_quiet_o == $past(mif.wdata[`CTL_TQ_BIT])
    ) else $error("free-run or quiet control not applied");

    a_sd_force: assert property (
        r.sd_override ##1 r.sd_override |-> signal_detect_o
    ) else $error("forced signal detect not reported");

    a_link_hold: assert property (
        link_up_o && r.sd && r.link_hold && !descrambler_lock_i |=> link_up_o
    ) else $error("link dropped on lock loss under hold policy");

    a_link_strict: assert property (
        link_up_o && !r.link_hold && !descrambler_lock_i |=> !link_up_o
    ) else $error("link held without lock under strict policy");

    a_link_sd_loss: assert property (
        link_up_o && !r.sd |=> !link_up_o
    ) else $error("link held without valid signal");

    a_desc_limit: assert property (
        descrambler_timeout_o |-> desc_limit_q == (desc_long_q ? 15'(DESC_LONG_CYC - 1) : 15'(DESC_SHORT_CYC - 1))
            && $past(r.desc_cnt) == desc_limit_q
    ) else $error("descrambler timeout at wrong count");

    a_page_reset: assert property (
        $rose(rst_n_i) |-> r.page == `PAGE_EXTENDED && r.link_hold
    ) else $error("page or hold policy wrong after reset");

    c_fc_saturated: cover property (r.fc_tally == `TALLY_MAX ##1 fc_clr);
    c_rx_counted: cover property (rx_count && !rx_clr);
    c_link_up: cover property (!link_up_o ##1 link_up_o);
    c_ctl_write: cover property (mif.wr_stb && page_hit(mif.addr, r.page, `ADDR_CODING_CTL));
    c_desc_timeout: cover property (descrambler_timeout_o);

endmodule
`default_nettype wire

// ==== shared/mgmt_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface mgmt_if;
    logic        rd_stb;
    logic        wr_stb;
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    modport engine (output rd_stb, output wr_stb, output addr, output wdata, input rdata);
    modport bank   (input rd_stb, input wr_stb, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ==== shared/phy_page_cfg.svh ====
`ifndef PHY_PAGE_CFG_SVH
`define PHY_PAGE_CFG_SVH

// Management register addresses
`define ADDR_PAGE_SEL    5'h13
`define ADDR_FC_TALLY    5'h14
`define ADDR_RX_TALLY    5'h15
`define ADDR_CODING_CTL  5'h16

// Page index field and encodings
`define PAGE_MSB         1
`define PAGE_LSB         0
`define PAGE_EXTENDED    2'h0
`define PAGE_TEST        2'h1
`define PAGE_DIAG        2'h2

// Coding sublayer control fields
`define CTL_FREE_BIT     11
`define CTL_TQ_BIT       10
`define CTL_SD_BIT       9
`define CTL_HOLD_BIT     8
`define CTL_DESC_BIT     7
`define CTL_HOLD_RST     1'h1

`define TALLY_MAX        8'hFF
`define TALLY_LSB        0
`define TALLY_MSB        7

// Timing
`define CLK_PERIOD_NS    100
`define DESC_SHORT_US    722
`define DESC_LONG_MS     2
`define DESC_SHORT_CYC   ((`DESC_SHORT_US * 1000) / `CLK_PERIOD_NS)
`define DESC_LONG_CYC    ((`DESC_LONG_MS * 1000000) / `CLK_PERIOD_NS)

// Management frame
`define PREAMBLE_LEN     6'h20
`define OP_READ          2'h2
`define OP_WRITE         2'h1
`define OP_LAST          6'h01
`define ADDR_LAST        6'h09
`define TA_LAST          6'h01
`define DATA_LAST        6'h0F

`endif

// ==== shared/phy_page_pkg.sv ====
`default_nettype none
package phy_page_pkg;

    typedef enum logic [2:0] {
        ST_PREAMBLE = 3'h0,
        ST_START    = 3'h1,
        ST_OP       = 3'h2,
        ST_ADDR     = 3'h3,
        ST_TA       = 3'h4,
        ST_DATA     = 3'h5
    } mdio_state_t;

    typedef struct packed {
        logic        mdc_s1;
        logic        mdc_s2;
        logic        mdc_d;
        logic        mdio_s1;
        logic        mdio_s2;
        mdio_state_t state;
        logic [5:0]  cnt;
        logic [15:0] shreg;
        logic        is_read;
        logic        phy_hit;
        logic [4:0]  reg_addr;
        logic        oe_n;
        logic        mdio_out;
        logic        rd_stb;
        logic        wr_stb;
    } mdio_eng_t;

    typedef struct packed {
        logic [1:0]  page;
        logic [7:0]  fc_tally;
        logic [7:0]  rx_tally;
        logic        free_clk;
        logic        true_quiet;
        logic        sd_override;
        logic        link_hold;
        logic        desc_long;
        logic        in_carrier;
        logic        err_seen;
        logic        coll_seen;
        logic        sd;
        logic        link;
        logic [14:0] desc_cnt;
        logic        desc_timeout;
        logic [15:0] rdata;
    } bank_state_t;

endpackage
`default_nettype wire

// ==== tb/mgmt_station_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module mgmt_station_model (
    // Clock
    input  wire logic   sys_clk_i,
    // Device side of the management pins
    input  wire logic   dev_mdio_i,
    input  wire logic   dev_oe_n_i,
    // Station side
    output logic        mdc_o,
    output logic        line_o,
    output logic        rd_valid_o,
    output logic [15:0] rd_data_o
);
    logic drv_en_reg;
    logic drv_bit_reg;

    // Pulled-up line: device when enabled, else station, else pull-up
    assign line_o = !dev_oe_n_i ? dev_mdio_i : (drv_en_reg ? drv_bit_reg : 1'b1);

    initial begin
        mdc_o = 1'b1;
        drv_en_reg = 1'b0;
        drv_bit_reg = 1'b1;
        rd_valid_o = 1'b0;
        rd_data_o = 16'h0000;
    end

    // One whole frame; the station lets go of the line from turnaround on reads
    task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] wd);
        logic [63:0] seq;
        logic [15:0] got;
        got = 16'h0000;
        seq = {32'hFFFF_FFFF, 2'b01, rd ? 2'b10 : 2'b01, phy, ra, 2'b10, wd & 16'hFFBF};
        for (int i = 63; i >= 0; i--) begin
            @(posedge sys_clk_i);
            mdc_o <= 1'b0;
            drv_en_reg <= !(rd && i < 18);
            drv_bit_reg <= seq[i];
            repeat (8) @(posedge sys_clk_i);
            if (i < 16) got = {got[14:0], line_o};
            mdc_o <= 1'b1;
            repeat (6) @(posedge sys_clk_i);
        end
        drv_en_reg <= 1'b0;
        if (rd) begin
            rd_data_o <= got;
            rd_valid_o <= 1'b1;
            @(posedge sys_clk_i);
            rd_valid_o <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ==== tb/phy_page_counters_pcs_config_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "phy_page_cfg.svh"
module phy_page_counters_pcs_config_tb;
    localparam int LS = 20;
    localparam int LL = 50;
    logic        sys_clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        mdc, line, mdio_o, oe_n, rd_valid;
    logic        fc, cv, inv, col, sig, lock, sync;
    logic [1:0]  page;
    logic        fr, tq, sd, lk, to;
    logic        probe, meas;
    logic [15:0] rd_data, meas_val, v;
    logic [15:0] status;
    int          n_errors = 0;
    int          tests_run = 0;
    int          seed = 32'hb5b4;
    logic [15:0] exp_q[$];

    assign status = {9'h0, page, fr, tq, sd, lk, to};
    always #50 sys_clk_i = ~sys_clk_i;

    phy_page_counters_pcs_config #(.PHY_ADDR(5'h01), .DESC_SHORT_CYC(LS), .DESC_LONG_CYC(LL)) uut (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .mdc_i(mdc), .mdio_i(line), .mdio_o(mdio_o),
        .mdio_oe_n_o(oe_n), .false_carrier_i(fc), .carrier_valid_i(cv), .invalid_symbol_i(inv),
        .collision_i(col), .signal_level_i(sig), .descrambler_lock_i(lock), .descrambler_sync_i(sync),
        .page_select_o(page), .rx_clk_free_run_o(fr), .true_quiet_o(tq), .signal_detect_o(sd),
        .link_up_o(lk), .descrambler_timeout_o(to));

    mgmt_station_model station (
        .sys_clk_i(sys_clk_i), .dev_mdio_i(mdio_o), .dev_oe_n_i(oe_n), .mdc_o(mdc), .line_o(line),
        .rd_valid_o(rd_valid), .rd_data_o(rd_data));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Oldest note against whatever result shows up
    always @(posedge sys_clk_i) begin
        if (rd_valid || probe || meas) begin
            if (exp_q.size() == 0) n_errors++;
            else check(rd_valid ? rd_data : (probe ? status : meas_val), exp_q.pop_front());
        end
    end

    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        station.frame(1'b1, 5'h01, a, 16'h0000);
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        station.frame(1'b0, 5'h01, a, d);
    endtask

    task automatic pr(input logic [15:0] e);
        repeat (4) @(posedge sys_clk_i);
        exp_q.push_back(e);
        probe <= 1'b1;
        @(posedge sys_clk_i);
        probe <= 1'b0;
    endtask

    // Expected status: page, then free-run, quiet, detect and link bits
    function automatic logic [15:0] st(input logic [1:0] p, input logic [3:0] b);
        return {9'h0, p, b, 1'b0};
    endfunction

    task automatic fc_pulses(input int n);
        repeat (n) begin
            @(posedge sys_clk_i);
            fc <= 1'b1;
            @(posedge sys_clk_i);
            fc <= 1'b0;
            repeat ($random(seed) & 3) @(posedge sys_clk_i);
        end
    endtask

    task automatic carrier(input int n_inv, input logic c);
        @(posedge sys_clk_i);
        cv <= 1'b1;
        col <= c;
        repeat (n_inv) begin
            @(posedge sys_clk_i);
            inv <= 1'b1;
            @(posedge sys_clk_i);
            inv <= 1'b0;
        end
        @(posedge sys_clk_i);
        cv <= 1'b0;
        col <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
    endtask

    // Cycles from a sync refresh to the timeout pulse, within a small window
    task automatic tmo(input int lim);
        int n;
        @(posedge sys_clk_i);
        sync <= 1'b1;
        @(posedge sys_clk_i);
        sync <= 1'b0;
        // Skip the edge before the restart lands, where an old timeout may still show
        @(posedge sys_clk_i);
        for (n = 1; n < 200 && to !== 1'b1; n++) @(posedge sys_clk_i);
        exp_q.push_back(16'h0001);
        meas_val <= 16'((n >= lim - 2) && (n <= lim + 2));
        meas <= 1'b1;
        @(posedge sys_clk_i);
        meas <= 1'b0;
    endtask

    initial begin
        {fc, cv, inv, col, sig, lock, sync, probe, meas} = '0;
        meas_val = 16'h0000;
        repeat (10) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        rd(`ADDR_PAGE_SEL, 16'h0000);
        rd(`ADDR_CODING_CTL, 16'h0100);
        pr(st(2'h0, 4'h0));
        wr(`ADDR_PAGE_SEL, 16'hFFFF);
        rd(`ADDR_PAGE_SEL, 16'h0003);
        fc_pulses(3);
        for (int p = 1; p < 4; p++) begin
            wr(`ADDR_PAGE_SEL, 16'(p));
            pr(st(2'(p), 4'h0));
            rd(`ADDR_FC_TALLY, 16'h0000);
        end
        wr(`ADDR_PAGE_SEL, 16'h0000);
        // Frames for another station address are ignored; the line stays pulled up
        station.frame(1'b0, 5'h02, `ADDR_PAGE_SEL, 16'h0003);
        exp_q.push_back(16'hFFFF);
        station.frame(1'b1, 5'h02, `ADDR_PAGE_SEL, 16'h0000);
        rd(`ADDR_PAGE_SEL, 16'h0000);
        wr(`ADDR_FC_TALLY, 16'h00AA);
        rd(`ADDR_FC_TALLY, 16'h0003);
        rd(`ADDR_FC_TALLY, 16'h0000);
        fc_pulses(300);
        rd(`ADDR_FC_TALLY, 16'h00FF);
        carrier(3, 1'b0);
        carrier(0, 1'b0);
        carrier(2, 1'b1);
        wr(`ADDR_RX_TALLY, 16'h0055);
        rd(`ADDR_RX_TALLY, 16'h0001);
        rd(`ADDR_RX_TALLY, 16'h0000);
        repeat (260) carrier(1, 1'b0);
        rd(`ADDR_RX_TALLY, 16'h00FF);
        for (int k = 0; k < 3; k++) begin
            v = (k == 0) ? 16'hFFFF : 16'($random(seed));
            wr(`ADDR_CODING_CTL, v);
            rd(`ADDR_CODING_CTL, v & 16'h0F80);
            pr(st(2'h0, {v[11:9], 1'b0}));
        end
        wr(`ADDR_CODING_CTL, 16'h0100);
        sig <= 1'b1;
        lock <= 1'b1;
        pr(st(2'h0, 4'h3));
        lock <= 1'b0;
        pr(st(2'h0, 4'h3));
        sig <= 1'b0;
        pr(st(2'h0, 4'h0));
        wr(`ADDR_CODING_CTL, 16'h0000);
        sig <= 1'b1;
        lock <= 1'b1;
        pr(st(2'h0, 4'h3));
        lock <= 1'b0;
        pr(st(2'h0, 4'h2));
        lock <= 1'b1;
        tmo(LS);
        wr(`ADDR_CODING_CTL, 16'h0080);
        tmo(LL);
        repeat (4) @(posedge sys_clk_i);
        report_and_stop();
    end

    initial begin
        repeat (60000) @(posedge sys_clk_i);
        n_errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
